/* verilog/acsw_top.sv */
/*
 * Digital control for a pair of analog comparators: single-shot
 * and continuous sequencing, ready flags, edge detection, window
 * pairing, sleep clock requests and AXI4-Lite registers.
 * Assumes comparator outputs and events synchronous to clk_sys.
 */
// What this block does
// - Single-shot comparator idles until triggered
// - Start write: warm up, compare once, stop
// - Start clears ready; completion sets it
// - Sync status read starts all enabled single-shots
// - Sync read stalls until enabled ones ready
// - Busy comparator finishes, no extra launch
// - Enabled event triggers its own comparator
// - Event start acts like software start
// - Edge: newest result versus previous result
// - Sleep event requests clock, then releases
// - Route pins and negative source by selects
// - Window enable bit turns window on
// - Window state correct for either order
// - Window interrupt per selected transition
// - Window event follows inside state
// - Single comparators keep working in window
// - Window single-shot starts both together
// - Doubler by supply, forced off by bit
// - Scaler on for select 0x5 while core powered
// - Continuous: compare each cycle after start-up
// - Top enable off idles all, bits kept
`timescale 1ns/100ps
module acsw_top (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Analog side
  input  wire logic [1:0]        comp_out,
  input  wire logic              supply_low,
  output acsw_pkg::acsw_ana_t    ana,
  // Events and system
  input  wire logic [1:0]        evt_in,
  input  wire logic              sleep_mode,
  input  wire logic              wake_en,
  output logic [1:0]             evt_comp,
  output logic                   evt_win,
  output logic [1:0]             irq_edge,
  output logic                   irq_win,
  output logic                   clk_req,
  output logic                   wake_req
);

  acsw_pkg::acsw_st_t st_r;   // Registered state
  acsw_pkg::acsw_st_t st_nxt; // Next state

  // Window position from the two results, either limit order
  function automatic acsw_pkg::acsw_win_t win_of(
    input logic [1:0] s
  );
    // One above its limit, one below: inside
    if (s[0] != s[1]) begin
      win_of = acsw_pkg::WS_IN;
    end else if (s[0]) begin
      win_of = acsw_pkg::WS_ABOVE;
    end else begin
      win_of = acsw_pkg::WS_BELOW;
    end
  endfunction

  // Aligned address compare
  function automatic logic hit(
    input logic [7:0] a,
    input logic [7:0] ofs
  );
    hit = ({a[7:2], 2'b00} == ofs);
  endfunction

  // Next-state logic
  always_comb begin
    logic [1:0]            en;     // Effective enables
    logic [1:0]            trig;   // Start requests
    logic [1:0]            go;     // Starts after pairing
    logic [1:0]            samp;   // Comparison taken
    logic                  wr;     // Register write now
    logic                  launch; // Sync read accepted
    logic                  pair;   // Window single-shot pair
    logic [31:0]           rd;     // Read data
    logic                  rd_ok;  // Read address mapped
    acsw_pkg::acsw_win_t   wn;     // New window state
    en     = '0;
    trig   = '0;
    go     = '0;
    samp   = '0;
    wr     = 1'b0;
    launch = 1'b0;
    pair   = 1'b0;
    rd     = '0;
    rd_ok  = 1'b1;
    wn     = st_r.wst;
    st_nxt = st_r;
    // Pulses last one cycle
    st_nxt.edg     = '0;
    st_nxt.win_irq = 1'b0;
    st_nxt.wake    = 1'b0;

    // Top enable gates all, keeps own bits
    for (int i = 0; i < 2; i++) begin
      en[i] = st_r.main_en & st_r.cc[i][acsw_pkg::CC_EN];
    end

    // Address and data capture
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_ok  = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_ok  = 1'b1;
      st_nxt.wdata = s_axi_wdata[7:0];
      st_nxt.wlane = s_axi_wstrb[0];
    end

    // Register write once both halves held
    if (st_r.aw_ok && st_r.w_ok && !st_r.bvalid) begin
      wr              = st_r.wlane;
      st_nxt.aw_ok    = 1'b0;
      st_nxt.w_ok     = 1'b0;
      st_nxt.bvalid   = 1'b1;
      st_nxt.bresp    = acsw_pkg::RESP_OK;
      case ({st_r.awaddr[7:2], 2'b00})
        acsw_pkg::OFS_MAIN: begin
          if (wr) begin
            st_nxt.main_en = st_r.wdata[acsw_pkg::MAIN_EN];
            st_nxt.dbl_dis = st_r.wdata[acsw_pkg::MAIN_DBL];
          end
        end
        acsw_pkg::OFS_START: begin
          // Software start bits
          if (wr) begin
            trig = st_r.wdata[1:0];
          end
        end
        acsw_pkg::OFS_EVT: begin
          if (wr) begin
            st_nxt.evin = st_r.wdata[1:0];
          end
        end
        acsw_pkg::OFS_WIN: begin
          if (wr) begin
            st_nxt.win_en  = st_r.wdata[acsw_pkg::WIN_EN];
            st_nxt.win_sel = st_r.wdata[acsw_pkg::WIN_SEL+:2];
          end
        end
        acsw_pkg::OFS_CC0: begin
          if (wr) begin
            st_nxt.cc[0] = st_r.wdata[6:0];
          end
        end
        acsw_pkg::OFS_CC1: begin
          if (wr) begin
            st_nxt.cc[1] = st_r.wdata[6:0];
          end
        end
        acsw_pkg::OFS_SCL0: begin
          if (wr) begin
            st_nxt.scl[0] = st_r.wdata[5:0];
          end
        end
        acsw_pkg::OFS_SCL1: begin
          if (wr) begin
            st_nxt.scl[1] = st_r.wdata[5:0];
          end
        end
        acsw_pkg::OFS_SU: begin
          if (wr) begin
            st_nxt.su = st_r.wdata;
          end
        end
        acsw_pkg::OFS_STATE,
        acsw_pkg::OFS_READY,
        acsw_pkg::OFS_SYNC: begin
          // Read-only, write ignored
        end
        default: begin
          st_nxt.bresp = acsw_pkg::RESP_ERR;
        end
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Read data mux
    case ({s_axi_araddr[7:2], 2'b00})
      acsw_pkg::OFS_MAIN:  rd = {30'h0, st_r.dbl_dis, st_r.main_en};
      acsw_pkg::OFS_START: rd = '0;
      acsw_pkg::OFS_EVT:   rd = {30'h0, st_r.evin};
      acsw_pkg::OFS_STATE: rd = {26'h0, st_r.wst, 2'h0, st_r.st};
      acsw_pkg::OFS_READY: rd = {30'h0, st_r.rdy};
      acsw_pkg::OFS_SYNC:  rd = '0;
      acsw_pkg::OFS_WIN:   rd = {29'h0, st_r.win_sel, st_r.win_en};
      acsw_pkg::OFS_CC0:   rd = {25'h0, st_r.cc[0]};
      acsw_pkg::OFS_CC1:   rd = {25'h0, st_r.cc[1]};
      acsw_pkg::OFS_SCL0:  rd = {26'h0, st_r.scl[0]};
      acsw_pkg::OFS_SCL1:  rd = {26'h0, st_r.scl[1]};
      acsw_pkg::OFS_SU:    rd = {24'h0, st_r.su};
      default: begin
        rd    = '0;
        rd_ok = 1'b0;
      end
    endcase

    // Read accept: sync status read launches and waits
    if (s_axi_arvalid && s_axi_arready) begin
      if (hit(s_axi_araddr, acsw_pkg::OFS_SYNC)) begin
        launch         = 1'b1;
        st_nxt.rd_wait = 1'b1;
      end else begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rdata  = rd;
        st_nxt.rresp  = rd_ok ? acsw_pkg::RESP_OK : acsw_pkg::RESP_ERR;
      end
    end
    // Stall until every enabled comparator is ready
    if (st_r.rd_wait && ((st_r.rdy | ~en) == 2'b11)) begin
      st_nxt.rd_wait = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rdata   = {28'h0, st_r.rdy, st_r.st};
      st_nxt.rresp   = acsw_pkg::RESP_OK;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Gather triggers: events and sync read
    for (int i = 0; i < 2; i++) begin
      trig[i] = trig[i] | (evt_in[i] & st_r.evin[i]) | launch;
    end
    // Window single-shot pair starts together
    pair = st_r.win_en & st_r.cc[0][acsw_pkg::CC_SINGLE]
         & st_r.cc[1][acsw_pkg::CC_SINGLE];
    go = pair ? {2{|trig}} : trig;

    // Per comparator sequencing
    for (int i = 0; i < 2; i++) begin
      case (st_r.ph[i])
        acsw_pkg::PH_IDLE: begin
          if (en[i] && !st_r.cc[i][acsw_pkg::CC_SINGLE]) begin
            // Continuous: first start-up
            st_nxt.ph[i]  = acsw_pkg::PH_WARM;
            st_nxt.cnt[i] = st_r.su;
          end else if (en[i] && go[i]) begin
            // Single-shot start; busy ones never get here
            st_nxt.ph[i]  = acsw_pkg::PH_WARM;
            st_nxt.cnt[i] = st_r.su;
            st_nxt.rdy[i] = 1'b0;
          end
        end
        acsw_pkg::PH_WARM: begin
          if (!en[i]) begin
            st_nxt.ph[i] = acsw_pkg::PH_IDLE;
          end else if (st_r.cnt[i] == 8'h00) begin
            // Start-up over, take one result
            samp[i]       = 1'b1;
            st_nxt.rdy[i] = 1'b1;
            st_nxt.ph[i]  = st_r.cc[i][acsw_pkg::CC_SINGLE]
                          ? acsw_pkg::PH_IDLE : acsw_pkg::PH_RUN;
          end else begin
            st_nxt.cnt[i] = st_r.cnt[i] - 8'h01;
          end
        end
        acsw_pkg::PH_RUN: begin
          if (!en[i] || st_r.cc[i][acsw_pkg::CC_SINGLE]) begin
            st_nxt.ph[i] = acsw_pkg::PH_IDLE;
          end else begin
            // Continuous sample every cycle
            samp[i]       = 1'b1;
            st_nxt.rdy[i] = 1'b1;
          end
        end
        default: begin
          st_nxt.ph[i] = acsw_pkg::PH_IDLE;
        end
      endcase
      // Result update and edge versus previous result
      if (samp[i]) begin
        st_nxt.st[i]  = comp_out[i];
        st_nxt.edg[i] = comp_out[i] ^ st_r.st[i];
      end
    end

    // Window state and its transition interrupt
    if (st_r.win_en && (samp != 2'b00)) begin
      wn         = win_of(st_nxt.st);
      st_nxt.wst = wn;
      if (wn != st_r.wst) begin
        case (st_r.win_sel)
          acsw_pkg::WSEL_ABOVE: st_nxt.win_irq = (wn == acsw_pkg::WS_ABOVE);
          acsw_pkg::WSEL_IN:    st_nxt.win_irq = (wn == acsw_pkg::WS_IN);
          acsw_pkg::WSEL_BELOW: st_nxt.win_irq = (wn == acsw_pkg::WS_BELOW);
          acsw_pkg::WSEL_OUT:   st_nxt.win_irq = (st_r.wst == acsw_pkg::WS_IN);
          default:              st_nxt.win_irq = 1'b0;
        endcase
      end
    end

    // Wake the system after a sleep measurement
    st_nxt.wake = sleep_mode & wake_en & (samp != 2'b00);
  end

  // State register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r    <= '0;
      st_r.su <= acsw_pkg::SU_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Analog core controls
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // Core powered only while warming or running
      ana.comp_en[i]    = (st_r.ph[i] != acsw_pkg::PH_IDLE);
      ana.pos_sel[i]    = st_r.cc[i][acsw_pkg::CC_POS+:2];
      ana.neg_sel[i]    = st_r.cc[i][acsw_pkg::CC_NEG+:3];
      ana.scaler_en[i]  = ana.comp_en[i]
                        & (ana.neg_sel[i] == acsw_pkg::NEG_SCALER);
      ana.scaler_val[i] = st_r.scl[i];
    end
    ana.doubler_en = supply_low & ~st_r.dbl_dis;
  end

  // Bus handshakes
  // Readies drop while a response waits, so one transfer per side
  assign s_axi_awready = ~st_r.aw_ok & ~st_r.bvalid;
  assign s_axi_wready  = ~st_r.w_ok & ~st_r.bvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = ~st_r.rd_wait & ~st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;

  // Events and pulses
  assign evt_comp = st_r.st;
  assign evt_win  = st_r.win_en & (st_r.wst == acsw_pkg::WS_IN);
  assign irq_edge = st_r.edg;
  assign irq_win  = st_r.win_irq;
  assign wake_req = st_r.wake;
  // Clock wanted while awake or any comparator busy
  assign clk_req  = ~sleep_mode | (st_r.ph[0] != acsw_pkg::PH_IDLE)
                  | (st_r.ph[1] != acsw_pkg::PH_IDLE) | st_r.rd_wait;

endmodule

/* verilog/acsw_pkg.sv */
/*
 * Shared constants and types of the comparator shot/window control.
 * Assumes a 32-bit AXI4-Lite host with 8-bit byte addresses.
 */
package acsw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MAIN  = 8'h00;  // main_control
  localparam logic [7:0] OFS_START = 8'h04;  // start_control, write only
  localparam logic [7:0] OFS_EVT   = 8'h08;  // event_control
  localparam logic [7:0] OFS_STATE = 8'h0c;  // state_status
  localparam logic [7:0] OFS_READY = 8'h10;  // ready_status
  localparam logic [7:0] OFS_SYNC  = 8'h14;  // sync_start_status
  localparam logic [7:0] OFS_WIN   = 8'h18;  // window_control
  localparam logic [7:0] OFS_CC0   = 8'h20;  // comparator_control_0
  localparam logic [7:0] OFS_CC1   = 8'h24;  // comparator_control_1
  localparam logic [7:0] OFS_SCL0  = 8'h28;  // supply_scaler_0
  localparam logic [7:0] OFS_SCL1  = 8'h2c;  // supply_scaler_1
  localparam logic [7:0] OFS_SU    = 8'h30;  // start-up count
  // Field positions
  localparam int MAIN_EN   = 0;  // Top-level enable
  localparam int MAIN_DBL  = 1;  // doubler_disable
  localparam int CC_EN     = 0;  // Comparator enable
  localparam int CC_SINGLE = 1;  // Single-shot select
  localparam int CC_POS    = 2;  // positive_input_select [3:2]
  localparam int CC_NEG    = 4;  // negative_input_select [6:4]
  localparam int WIN_EN    = 0;  // window_enable_0
  localparam int WIN_SEL   = 1;  // window_interrupt_select [2:1]
  localparam int ST_WST    = 4;  // window_state_0 [5:4]
  // Values
  localparam logic [2:0] NEG_SCALER = 3'h5;   // Scaler as negative input
  localparam logic [7:0] SU_RST     = 8'h10;  // Start-up count at reset
  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;
  // Window interrupt selections
  localparam logic [1:0] WSEL_ABOVE = 2'h0;
  localparam logic [1:0] WSEL_IN    = 2'h1;
  localparam logic [1:0] WSEL_BELOW = 2'h2;
  localparam logic [1:0] WSEL_OUT   = 2'h3;

  // Window state encoding
  typedef enum logic [1:0] {
    WS_ABOVE = 2'h0,
    WS_IN    = 2'h1,
    WS_BELOW = 2'h2
  } acsw_win_t;

  // Comparator phase, Gray along idle-warm-run
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_WARM = 2'h1,
    PH_RUN  = 2'h3
  } acsw_ph_t;

  // Controls toward the analog cores
  typedef struct packed {
    logic [1:0]      comp_en;    // Comparator cores powered
    logic [1:0][1:0] pos_sel;    // Positive pin per comparator
    logic [1:0][2:0] neg_sel;    // Negative source per comparator
    logic [1:0]      scaler_en;  // Supply scaler channel on
    logic [1:0][5:0] scaler_val; // Scaler level, 64 steps
    logic            doubler_en; // Mux voltage doubler on
  } acsw_ana_t;

  // Whole state of the block
  typedef struct packed {
    acsw_ph_t [1:0]  ph;
    logic [1:0][7:0] cnt;
    logic [1:0]      rdy;
    logic [1:0]      st;
    logic [1:0]      edg;
    logic            main_en;
    logic            dbl_dis;
    logic [1:0][6:0] cc;
    logic [1:0][5:0] scl;
    logic [1:0]      evin;
    logic            win_en;
    logic [1:0]      win_sel;
    acsw_win_t       wst;
    logic            win_irq;
    logic [7:0]      su;
    logic            wake;
    logic            aw_ok;
    logic            w_ok;
    logic [7:0]      awaddr;
    logic [7:0]      wdata;
    logic            wlane;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            rd_wait;
  } acsw_st_t;
endpackage

/* verif/acsw_props.sv */
/* Port checker for the comparator shot/window control.
   Assumes it is bound onto acsw_top, one clock domain clk_sys. */
`timescale 1ns/100ps
module acsw_props (
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [7:0]          s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic                supply_low,
  input wire acsw_pkg::acsw_ana_t ana,
  input wire logic                sleep_mode,
  input wire logic [1:0]          evt_comp,
  input wire logic                evt_win,
  input wire logic [1:0]          irq_edge,
  input wire logic                irq_win,
  input wire logic                clk_req
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Sync status read accepted
  sequence sync_taken;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == acsw_pkg::OFS_SYNC;
  endsequence
  // Held back one edge at least, then answered
  sequence stall_answer;
    !s_axi_rvalid ##[1:300] s_axi_rvalid;
  endsequence
  chk_sync_stall: assert property (sync_taken |=> stall_answer)
    else $error("sync read not stalled or never answered");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_scaler_gate: assert property (ana.scaler_en == (ana.comp_en &
    {ana.neg_sel[1] == 3'h5, ana.neg_sel[0] == 3'h5})) else $error("scaler gate wrong");
  chk_doubler_off: assert property (!supply_low |-> !ana.doubler_en)
    else $error("doubler on at high supply");
  chk_win_event: assert property (evt_win |-> evt_comp[0] != evt_comp[1])
    else $error("window event while outside");
  chk_edge_cause: assert property (irq_edge[0] |-> $changed(evt_comp[0]))
    else $error("edge pulse without result change");
  chk_edge_seen: assert property ($changed(evt_comp[1]) |-> irq_edge[1])
    else $error("result change without edge pulse");
  chk_win_irq: assert property (irq_win |-> evt_comp != $past(evt_comp))
    else $error("window pulse without transition");
  chk_awake_clk: assert property (!sleep_mode |-> clk_req)
    else $error("clock request low while awake");
endmodule
bind acsw_top acsw_props u_props (.clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .supply_low,
  .ana, .sleep_mode, .evt_comp, .evt_win, .irq_edge, .irq_win, .clk_req);

/* verif/acsw_ana_model.sv */
/* Behavioural model of the two analog comparator cores.
   Assumes pin levels from the bench and controls from acsw_top. */
`timescale 1ns/100ps
module acsw_ana_model (
  input  wire logic                clk_sys,
  input  wire acsw_pkg::acsw_ana_t ana,
  input  wire logic [3:0][5:0]     pin_lv,
  output logic [1:0]               comp_out
);
  logic [1:0] junk_r = 2'h1;  // Toggles while a core is unpowered
  logic [5:0] neg_lv [2];     // Level at each negative terminal
  // Unpowered cores give no steady answer
  always @(posedge clk_sys) junk_r <= ~junk_r;
  // Terminal routing and comparison per core
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      neg_lv[i] = (ana.neg_sel[i] == 3'h5) ? ana.scaler_val[i]
                                          : {ana.neg_sel[i], 3'h0};
      comp_out[i] = ana.comp_en[i] ? (pin_lv[ana.pos_sel[i]] > neg_lv[i]) : junk_r[i];
    end
  end
endmodule

/* verif/acsw_tb_top.sv */
/* Self-checking bench of the comparator shot/window control.
   Assumes acsw_top, the core model and the bound port checker. */
`timescale 1ns/100ps
module acsw_tb_top;
  logic             clk_sys = 1'b0;
  logic             sys_rst = 1'b1;
  logic [7:0]       awaddr = 8'h0, araddr = 8'h0, lfsr = 8'h12;
  logic [31:0]      wdata = 32'h0;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic             arvalid = 1'b0, rready = 1'b0;
  logic [1:0]       evt_in = 2'h0, comp_out, evt_comp, irq_edge, s_axi_bresp, s_axi_rresp;
  logic             supply_low = 1'b0, sleep_mode = 1'b0, wake_en = 1'b0, wake_seen = 1'b0;
  logic [3:0][5:0]  pin_lv = {6'h0, 6'h0, 6'h10, 6'h30};  // Analog pin levels
  logic [5:0]       scl;                                  // Random scaler level
  logic             o0;                                   // Expected first result
  logic             win_seen = 1'b0;                      // Window pulse observed
  logic [31:0]      s_axi_rdata;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic             evt_win, irq_win, clk_req, wake_req;
  acsw_pkg::acsw_ana_t ana;
  logic [33:0]      exp_q[$];                             // Expected {resp, data}
  int               error_cnt = 0, comparisons = 0;
  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;
  acsw_top DUT (.clk_sys, .sys_rst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready, .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(rready), .comp_out, .supply_low, .ana,
    .evt_in, .sleep_mode, .wake_en, .evt_comp, .evt_win, .irq_edge, .irq_win, .clk_req,
    .wake_req);
  acsw_ana_model u_cores (.clk_sys, .ana, .pin_lv, .comp_out);
  // Counted comparison
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // AXI4-Lite write, response accepted two edges after it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [3:0] hs;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(negedge clk_sys);
      hs = {s_axi_awready, s_axi_wready, s_axi_bvalid, bready};
      @(posedge clk_sys);
      if (hs[3]) awvalid <= 1'b0;
      if (hs[2]) wvalid <= 1'b0;
      if (hs[1]) bready <= !hs[0];
    end while (!(hs[1] && hs[0]));
  endtask
  // AXI4-Lite read, expectation noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic [3:0] hs;
    exp_q.push_back({r, d});
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk_sys);
      hs = {s_axi_arready, 1'b0, s_axi_rvalid, rready};
      @(posedge clk_sys);
      if (hs[3]) arvalid <= 1'b0;
      if (hs[1]) rready <= !hs[0];
    end while (!(hs[1] && hs[0]));
  endtask
  // Wait for a core to reach a power state
  task automatic wait_pw(input int i, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (ana.comp_en[i] !== v && n < 300);
    cmp(34'(ana.comp_en[i]), 34'(v));
  endtask
  // One-cycle peripheral event
  task automatic pulse(input logic [1:0] v);
    @(posedge clk_sys);
    evt_in <= v;
    @(posedge clk_sys);
    evt_in <= 2'h0;
  endtask
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Window state expected from both results
  function automatic logic [1:0] ws(input logic a, input logic b);
    return (a && b) ? acsw_pkg::WS_ABOVE : ((a || b) ? acsw_pkg::WS_IN : acsw_pkg::WS_BELOW);
  endfunction
  // Read results checked against the oldest note
  always @(negedge clk_sys) begin
    if (s_axi_rvalid && rready) cmp({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (wake_req) wake_seen <= 1'b1;
    if (irq_win) win_seen <= 1'b1;
  end
  task automatic final_report;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, 20000 cycles
  initial begin
    #800000;
    error_cnt++;
    final_report;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(acsw_pkg::OFS_SU, 32'h10, acsw_pkg::RESP_OK);
    rd(8'h3c, 32'h0, acsw_pkg::RESP_ERR);
    lfsr = lfsr_next(lfsr);
    scl = lfsr[5:0];
    o0 = 6'h30 > scl;
    wr(acsw_pkg::OFS_SU, 32'h8);
    wr(acsw_pkg::OFS_MAIN, 32'h1);
    wr(acsw_pkg::OFS_SCL0, {26'h0, scl});
    wr(acsw_pkg::OFS_CC0, 32'h53);
    wr(acsw_pkg::OFS_CC1, 32'h43);
    repeat (20) @(negedge clk_sys);
    cmp(34'(ana.comp_en), 34'h0);
    rd(acsw_pkg::OFS_SYNC, {28'h0, 2'h3, 1'b1, o0}, acsw_pkg::RESP_OK);
    pin_lv[0] <= 6'h18;
    o0 = 6'h18 > scl;
    wr(acsw_pkg::OFS_START, 32'h1);
    wait_pw(0, 1'b1);
    cmp(34'(ana.scaler_en), 34'h1);
    rd(acsw_pkg::OFS_READY, 32'h2, acsw_pkg::RESP_OK);
    wait_pw(0, 1'b0);
    rd(acsw_pkg::OFS_READY, 32'h3, acsw_pkg::RESP_OK);
    rd(acsw_pkg::OFS_STATE, {30'h0, 1'b1, o0}, acsw_pkg::RESP_OK);
    wr(acsw_pkg::OFS_EVT, 32'h2);
    pulse(2'h3);
    wait_pw(1, 1'b1);
    cmp(34'(ana.comp_en), 34'h2);
    wait_pw(1, 1'b0);
    rd(acsw_pkg::OFS_STATE, {30'h0, 1'b0, o0}, acsw_pkg::RESP_OK);
    wr(acsw_pkg::OFS_WIN, 32'h1);
    wr(acsw_pkg::OFS_START, 32'h2);
    wait_pw(0, 1'b1);
    cmp(34'(ana.comp_en), 34'h3);
    wait_pw(0, 1'b0);
    rd(acsw_pkg::OFS_STATE, {26'h0, ws(o0, 1'b0), 3'h0, o0}, acsw_pkg::RESP_OK);
    cmp(34'({win_seen, evt_win}), 34'(ws(o0, 1'b0) == acsw_pkg::WS_IN));
    @(posedge clk_sys);
    pin_lv[0] <= 6'h3f;
    o0 = 6'h3f > scl;
    sleep_mode <= 1'b1;
    wake_en <= 1'b1;
    pulse(2'h2);
    wait_pw(1, 1'b1);
    cmp(34'({ana.comp_en, clk_req}), 34'h7);
    wait_pw(1, 1'b0);
    repeat (3) @(negedge clk_sys);
    cmp(34'({wake_seen, win_seen, clk_req}), 34'h6);
    rd(acsw_pkg::OFS_STATE, {26'h0, ws(o0, 1'b1), 3'h1, o0}, acsw_pkg::RESP_OK);
    sleep_mode <= 1'b0;
    supply_low <= 1'b1;
    wr(acsw_pkg::OFS_MAIN, 32'h3);
    @(negedge clk_sys);
    cmp(34'(ana.doubler_en), 34'h0);
    wr(acsw_pkg::OFS_MAIN, 32'h0);
    @(negedge clk_sys);
    cmp(34'(ana.doubler_en), 34'h1);
    wr(acsw_pkg::OFS_START, 32'h3);
    repeat (12) @(negedge clk_sys);
    cmp(34'(ana.comp_en), 34'h0);
    rd(acsw_pkg::OFS_CC0, 32'h53, acsw_pkg::RESP_OK);
    final_report;
  end
endmodule
